//--- sph_pkg.sv
package sph_pkg;

  // Core clock period in nanoseconds (250 MHz).
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Thermistor bias settling dwell: a least time, so the count rounds up.
  localparam int unsigned DWELL_NS     = 2500000;
  localparam int unsigned DWELL_CYCLES = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Longest sleep entry wait per chain rate: longest times, so counts round down.
  localparam int unsigned SLEEP_WAIT_US_500K  = 500;
  localparam int unsigned SLEEP_WAIT_US_250K  = 1000;
  localparam int unsigned SLEEP_WAIT_US_125K  = 2000;
  localparam int unsigned SLEEP_WAIT_US_62K5  = 4000;
  localparam int unsigned SLEEP_CYC_500K = SLEEP_WAIT_US_500K * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYC_250K = SLEEP_WAIT_US_250K * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYC_125K = SLEEP_WAIT_US_125K * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYC_62K5 = SLEEP_WAIT_US_62K5 * 1000 / CLK_PERIOD_NS;

  // Wakeup tone: 4 kHz, half period in core cycles, and number of full tone cycles.
  localparam int unsigned TONE_HZ         = 4000;
  localparam int unsigned TONE_HALF_CYC   = 1000000000 / (CLK_PERIOD_NS * TONE_HZ * 2);
  localparam int unsigned TONE_CYCLES     = 4;

  // Top device wait before its wakeup acknowledge.
  localparam int unsigned TOP_WAIT_US     = 5000;
  localparam int unsigned TOP_WAIT_CYC    = TOP_WAIT_US * 1000 / CLK_PERIOD_NS;

  // Counter and data widths.
  localparam int unsigned CNT_W    = 21;
  localparam int unsigned RESULT_W = 14;
  localparam int unsigned CHAN_W   = 3;
  localparam int unsigned CSUM_W   = 16;
  localparam int unsigned EXT_N    = 4;

  // Conversion channel map: external inputs first, then internal sources.
  localparam logic [2:0] CH_EXT_LAST = 3'h3;
  localparam logic [2:0] CH_SCAN_LAST = 3'h7;

  // Reset values.
  localparam logic [3:0] CHECK_EN_RESET = 4'h0;

  // Commands handed over by the frame decoder.
  typedef enum logic [3:0] {
    SPH_OP_NONE       = 4'h0,
    SPH_OP_SCAN_TEMPS = 4'h1,
    SPH_OP_MEAS_TEMP  = 4'h2,
    SPH_OP_SLEEP      = 4'h3,
    SPH_OP_WAKEUP     = 4'h4,
    SPH_OP_RESET      = 4'h5,
    SPH_OP_CALC_CSUM  = 4'h6,
    SPH_OP_CHECK_CSUM = 4'h7,
    SPH_OP_BAL_ENABLE = 4'h8
  } sph_op_t;

  // Responses handed back to the frame encoder.
  typedef enum logic [1:0] {
    SPH_RSP_ACK   = 2'h0,
    SPH_RSP_NAK   = 2'h1,
    SPH_RSP_FAULT = 2'h2,
    SPH_RSP_ECHO  = 2'h3
  } sph_rsp_t;

  // Chain data rate selection.
  typedef enum logic [1:0] {
    SPH_RATE_500K = 2'h0,
    SPH_RATE_250K = 2'h1,
    SPH_RATE_125K = 2'h2,
    SPH_RATE_62K5 = 2'h3
  } sph_rate_t;

  // One decoded command.
  typedef struct packed {
    sph_op_t           op;
    logic              broadcast;
    logic [CHAN_W-1:0] chan;
  } sph_cmd_t;

  // One response.
  typedef struct packed {
    logic     valid;
    sph_rsp_t code;
  } sph_resp_t;

endpackage : sph_pkg

//--- sph_result_mem.sv
module sph_result_mem #(
  parameter int unsigned WIDTH  = 14,
  parameter int unsigned ADDR_W = 3
) (
  // Clock.
  input  wire logic              core_clk,
  // Write port.
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]  wrData,
  // Read port.
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [WIDTH-1:0]  rdData
);

  // Result storage; contents are undefined until the first conversion.
  logic [WIDTH-1:0] mem [2**ADDR_W];

  // Write and registered read; no reset so it maps onto plain storage.
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule : sph_result_mem

//--- sph_command_handler.sv
// Function
// - Bias on, 2.5 ms dwell, convert, bias off.
// - Store each 14-bit result per input.
// - Scan also converts die, reference, loopback.
// - Enabled inputs fault below threshold; enables reset 0.
// - Sleep keeps comms, scans and balancing alive.
// - Sleep only broadcast; addressed sleep gets NAK.
// - Top device acknowledges a valid sleep.
// - Sleep wait; port 1 traffic cancels, repeat restarts.
// - Sleep entry within rate-dependent maximum wait.
// - No comm timeout; watchdog expiry forces sleep.
// - Asleep, a valid wakeup command wakes the master; others wake on the tone.
// - Wake sends 4 kHz tone; relays pass on.
// - Ignore port 1 while sending wake tone.
// - Top waits, then acknowledges the wakeup.
// - Wakeup answers ACK, none, or echo.
// - Stack wakeup within size-dependent time bound.
// - Reset command restores all power-up values; chan, scanAll and the counters are kept.
// - Broadcast reset ignored; host resets top down.
// - Calculate stores checksum; check faults on mismatch.
// - Balance enable sets run bit, broadcast too.
module sph_command_handler #(
  parameter int unsigned DWELL_CYC  = sph_pkg::DWELL_CYCLES,
  parameter int unsigned SLEEP_500K = sph_pkg::SLEEP_CYC_500K,
  parameter int unsigned SLEEP_250K = sph_pkg::SLEEP_CYC_250K,
  parameter int unsigned SLEEP_125K = sph_pkg::SLEEP_CYC_125K,
  parameter int unsigned SLEEP_62K5 = sph_pkg::SLEEP_CYC_62K5,
  parameter int unsigned TONE_HALF  = sph_pkg::TONE_HALF_CYC,
  parameter int unsigned TOP_WAIT   = sph_pkg::TOP_WAIT_CYC,
  parameter int unsigned IMAGE_W    = 64
) (
  // Clock and reset.
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  // Decoded commands from port 1 and chain role.
  input  wire logic                            cmdValid,
  input  wire sph_pkg::sph_cmd_t               cmd,
  input  wire logic                            port1Activity,
  input  wire logic                            isMaster,
  input  wire logic                            isTop,
  input  wire sph_pkg::sph_rate_t              rateSel,
  input  wire logic                            scanRequest,
  // Watchdog and balancing companions.
  input  wire logic                            wdtExpired,
  input  wire logic                            wdtEnable,
  input  wire logic                            balanceStop,
  // Fault configuration and clear.
  input  wire logic                            cfgLoad,
  input  wire logic [sph_pkg::EXT_N-1:0]       cfgCheckEn,
  input  wire logic [sph_pkg::RESULT_W-1:0]    extThreshold,
  input  wire logic                            faultClear,
  // Volatile register image for checksums.
  input  wire logic [IMAGE_W-1:0]              regImage,
  // Converter handshake.
  output logic                                 adcStart,
  output logic      [sph_pkg::CHAN_W-1:0]      adcChan,
  input  wire logic                            adcDone,
  input  wire logic [sph_pkg::RESULT_W-1:0]    adcData,
  // Result read port.
  input  wire logic [sph_pkg::CHAN_W-1:0]      resultAddr,
  output logic      [sph_pkg::RESULT_W-1:0]    resultData,
  // Wakeup tone pins.
  input  wire logic                            toneIn,
  output logic                                 toneOut,
  // Status and responses.
  output logic                                 thermistor_bias_output,
  output logic      [sph_pkg::EXT_N-1:0]       tempFault,
  output logic      [sph_pkg::EXT_N-1:0]       ext_temp_check_enables,
  output logic                                 sleepMode,
  output logic                                 balance_run_bit,
  output logic                                 softReset,
  output logic      [sph_pkg::CSUM_W-1:0]      storedChecksum,
  output sph_pkg::sph_resp_t                   resp
);

  // Folds the register image into one checksum word by XOR of slices.
  function automatic logic [sph_pkg::CSUM_W-1:0] foldImage(input logic [IMAGE_W-1:0] img);
    logic [sph_pkg::CSUM_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < IMAGE_W / sph_pkg::CSUM_W; i++)
    begin
      acc = acc ^ img[i*sph_pkg::CSUM_W +: sph_pkg::CSUM_W];
    end
    return acc;
  endfunction : foldImage

  // Temperature sequencer states.
  typedef enum logic [1:0] {
    T_IDLE = 2'h0, T_DWELL = 2'h1, T_START = 2'h2, T_WAIT = 2'h3
  } sph_tstate_t;

  // Power state machine states.
  typedef enum logic [2:0] {
    P_AWAKE = 3'h0, P_SLEEP_WAIT = 3'h1, P_ASLEEP = 3'h2, P_WAKE_TX = 3'h3, P_TOP_WAIT = 3'h4
  } sph_pstate_t;

  sph_tstate_t                tState, next_tState;      // Sequencer state.
  logic [sph_pkg::CNT_W-1:0]  tCnt, next_tCnt;          // Dwell counter.
  logic [sph_pkg::CHAN_W-1:0] chan, next_chan;          // Channel being converted.
  logic                       scanAll, next_scanAll;    // Full scan versus single input.
  logic                       bias, next_bias;          // Bias output state.
  logic [sph_pkg::EXT_N-1:0]  fault, next_fault;        // Sticky threshold faults.
  logic [sph_pkg::EXT_N-1:0]  checkEn, next_checkEn;    // Per-input check enables.
  sph_pstate_t                pState, next_pState;      // Power state.
  logic [sph_pkg::CNT_W-1:0]  pCnt, next_pCnt;          // Power timer.
  logic [3:0]                 toneCnt, next_toneCnt;    // Tone half periods sent.
  logic                       tone, next_tone;          // Tone output level.
  logic                       balRun, next_balRun;      // Balance run bit.
  logic                       swRst, next_swRst;        // Software reset pulse.
  logic [sph_pkg::CSUM_W-1:0] csum, next_csum;          // Stored checksum.
  sph_pkg::sph_resp_t         rsp, next_rsp;            // Response strobe.
  logic                       toneMeta, toneSync, tonePrev; // Tone input synchroniser.
  logic                       accept;                   // Command taken this cycle.
  logic                       wrEn;                     // Result write strobe.
  logic [sph_pkg::CNT_W-1:0]  sleepWait;                // Wait for selected rate.

  // The tone pin is asynchronous: two flops, then an edge detect on the second.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      toneMeta <= 1'b0;
      toneSync <= 1'b0;
      tonePrev <= 1'b0;
    end
    else
    begin
      toneMeta <= toneIn;
      toneSync <= toneMeta;
      tonePrev <= toneSync;
    end
  end

  // Commands are dropped while our own tone is on port 2, since the tone echoes back.
  assign accept = cmdValid && (pState != P_WAKE_TX);

  // Sleep wait per rate; each is at most the longest allowed entry time.
  always_comb
  begin
    case (rateSel)
      sph_pkg::SPH_RATE_500K: sleepWait = sph_pkg::CNT_W'(SLEEP_500K);
      sph_pkg::SPH_RATE_250K: sleepWait = sph_pkg::CNT_W'(SLEEP_250K);
      sph_pkg::SPH_RATE_125K: sleepWait = sph_pkg::CNT_W'(SLEEP_125K);
      default:                sleepWait = sph_pkg::CNT_W'(SLEEP_62K5);
    endcase
  end

  // Temperature sequencer next state; runs in sleep as well so timed scans work.
  always_comb
  begin
    next_tState  = tState;
    next_tCnt    = tCnt;
    next_chan    = chan;
    next_scanAll = scanAll;
    next_bias    = bias;
    next_fault   = fault & ~{sph_pkg::EXT_N{faultClear}};
    next_checkEn = cfgLoad ? cfgCheckEn : checkEn;
    wrEn         = 1'b0;
    case (tState)
      T_IDLE:
      begin
        // A request arriving mid-scan is simply not started.
        if ((accept && cmd.op == sph_pkg::SPH_OP_SCAN_TEMPS) || scanRequest)
        begin
          next_tState  = T_DWELL;
          next_scanAll = 1'b1;
          next_chan    = '0;
          next_bias    = 1'b1;
          next_tCnt    = '0;
        end
        else if (accept && cmd.op == sph_pkg::SPH_OP_MEAS_TEMP)
        begin
          next_tState  = T_DWELL;
          next_scanAll = 1'b0;
          next_chan    = cmd.chan & sph_pkg::CH_EXT_LAST;
          next_bias    = 1'b1;
          next_tCnt    = '0;
        end
      end
      T_DWELL:
      begin
        // Let the thermistor networks settle before the first conversion.
        next_tCnt = tCnt + 1'b1;
        if (tCnt == sph_pkg::CNT_W'(DWELL_CYC - 1))
        begin
          next_tState = T_START;
        end
      end
      T_START:
      begin
        next_tState = T_WAIT;
      end
      T_WAIT:
      begin
        if (adcDone)
        begin
          wrEn = 1'b1;
          if (chan <= sph_pkg::CH_EXT_LAST && checkEn[chan[1:0]] && adcData < extThreshold)
          begin
            next_fault[chan[1:0]] = 1'b1;
          end
          if (scanAll && chan != sph_pkg::CH_SCAN_LAST)
          begin
            next_chan   = chan + 1'b1;
            next_tState = T_START;
          end
          else
          begin
            next_bias   = 1'b0;
            next_tState = T_IDLE;
          end
        end
      end
      default:
      begin
        next_tState = T_IDLE;
      end
    endcase
    if (swRst)
    begin
      next_tState  = T_IDLE;
      next_bias    = 1'b0;
      next_fault   = '0;
      next_checkEn = sph_pkg::CHECK_EN_RESET;
    end
  end

  // Power, balance, checksum and response next state.
  always_comb
  begin
    next_pState  = pState;
    next_pCnt    = pCnt;
    next_toneCnt = toneCnt;
    next_tone    = tone;
    next_balRun  = balRun & ~balanceStop;
    next_swRst   = 1'b0;
    next_csum    = csum;
    next_rsp     = '{valid: 1'b0, code: sph_pkg::SPH_RSP_ACK};
    case (pState)
      P_AWAKE, P_SLEEP_WAIT:
      begin
        // Other port 1 traffic cancels a pending sleep.
        if (pState == P_SLEEP_WAIT)
        begin
          next_pCnt = pCnt + 1'b1;
          if (port1Activity && !(accept && cmd.op == sph_pkg::SPH_OP_SLEEP))
          begin
            next_pState = P_AWAKE;
          end
          else if (pCnt >= sleepWait - 1'b1)
          begin
            next_pState = P_ASLEEP;
          end
        end
        if (accept)
        begin
          case (cmd.op)
            sph_pkg::SPH_OP_SLEEP:
            begin
              if (cmd.broadcast)
              begin
                next_pState = P_SLEEP_WAIT;
                next_pCnt   = '0;
                next_rsp    = '{valid: isTop, code: sph_pkg::SPH_RSP_ACK};
              end
              else
              begin
                next_rsp = '{valid: 1'b1, code: sph_pkg::SPH_RSP_NAK};
              end
            end
            sph_pkg::SPH_OP_WAKEUP:
            begin
              // Already awake: top acknowledges a broadcast, a target echoes.
              next_rsp = cmd.broadcast ? '{valid: isTop, code: sph_pkg::SPH_RSP_ACK}
                                       : '{valid: 1'b1, code: sph_pkg::SPH_RSP_ECHO};
            end
            sph_pkg::SPH_OP_RESET:
            begin
              next_swRst = !cmd.broadcast;
            end
            sph_pkg::SPH_OP_CALC_CSUM:
            begin
              next_csum = foldImage(regImage);
            end
            sph_pkg::SPH_OP_CHECK_CSUM:
            begin
              if (foldImage(regImage) != csum)
              begin
                next_rsp = '{valid: 1'b1, code: sph_pkg::SPH_RSP_FAULT};
              end
            end
            sph_pkg::SPH_OP_BAL_ENABLE:
            begin
              next_balRun = 1'b1;
            end
            default:
            begin
            end
          endcase
        end
        // Lost link: no comm timeout on sleep, but the watchdog still puts us down.
        if (wdtEnable && wdtExpired)
        begin
          next_pState = P_ASLEEP;
        end
      end
      P_ASLEEP:
      begin
        // Balancing enables are still honoured; a broadcast wakeup on the master, or a tone edge, wakes.
        if (accept && cmd.op == sph_pkg::SPH_OP_BAL_ENABLE)
        begin
          next_balRun = 1'b1;
        end
        if ((isMaster && accept && cmd.op == sph_pkg::SPH_OP_WAKEUP && cmd.broadcast)
            || (toneSync && !tonePrev))
        begin
          next_pState  = P_WAKE_TX;
          next_pCnt    = '0;
          next_toneCnt = '0;
          next_tone    = 1'b1;
        end
      end
      P_WAKE_TX:
      begin
        // Drive a few cycles of the tone toward the next device.
        next_pCnt = pCnt + 1'b1;
        if (pCnt == sph_pkg::CNT_W'(TONE_HALF - 1))
        begin
          next_pCnt    = '0;
          next_toneCnt = toneCnt + 1'b1;
          next_tone    = !tone;
          if (toneCnt == 4'(2 * sph_pkg::TONE_CYCLES - 1))
          begin
            next_tone   = 1'b0;
            next_pState = isTop ? P_TOP_WAIT : P_AWAKE;
          end
        end
      end
      P_TOP_WAIT:
      begin
        // Give a tone started elsewhere in the stack time to arrive first.
        next_pCnt = pCnt + 1'b1;
        if (pCnt == sph_pkg::CNT_W'(TOP_WAIT - 1))
        begin
          next_pState = P_AWAKE;
          next_rsp    = '{valid: 1'b1, code: sph_pkg::SPH_RSP_ACK};
        end
      end
      default:
      begin
        next_pState = P_AWAKE;
      end
    endcase
    if (swRst)
    begin
      next_pState = P_AWAKE;
      next_tone   = 1'b0;
      next_balRun = 1'b0;
      next_csum   = '0;
    end
  end

  // Register all control state.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tState  <= T_IDLE;
      tCnt    <= '0;
      chan    <= '0;
      scanAll <= 1'b0;
      bias    <= 1'b0;
      fault   <= '0;
      checkEn <= sph_pkg::CHECK_EN_RESET;
      pState  <= P_AWAKE;
      pCnt    <= '0;
      toneCnt <= '0;
      tone    <= 1'b0;
      balRun  <= 1'b0;
      swRst   <= 1'b0;
      csum    <= '0;
      rsp     <= '{valid: 1'b0, code: sph_pkg::SPH_RSP_ACK};
    end
    else
    begin
      tState  <= next_tState;
      tCnt    <= next_tCnt;
      chan    <= next_chan;
      scanAll <= next_scanAll;
      bias    <= next_bias;
      fault   <= next_fault;
      checkEn <= next_checkEn;
      pState  <= next_pState;
      pCnt    <= next_pCnt;
      toneCnt <= next_toneCnt;
      tone    <= next_tone;
      balRun  <= next_balRun;
      swRst   <= next_swRst;
      csum    <= next_csum;
      rsp     <= next_rsp;
    end
  end

  // Conversion results, one word per channel.
  sph_result_mem #(.WIDTH(sph_pkg::RESULT_W), .ADDR_W(sph_pkg::CHAN_W)) resultMem (
    .core_clk (core_clk),
    .wrEn     (wrEn),
    .wrAddr   (chan),
    .wrData   (adcData),
    .rdAddr   (resultAddr),
    .rdData   (resultData)
  );

  // Output mapping.
  assign adcStart               = (tState == T_START);
  assign adcChan                = chan;
  assign toneOut                = tone;
  assign thermistor_bias_output = bias;
  assign tempFault              = fault;
  assign ext_temp_check_enables = checkEn;
  assign sleepMode              = (pState == P_ASLEEP);
  assign balance_run_bit        = balRun;
  assign softReset              = swRst;
  assign storedChecksum         = csum;
  assign resp                   = rsp;

  // Bias is on throughout each conversion.
  bias_conv_a :
    assert property (@(posedge core_clk) disable iff (reset)
      (tState == T_START || tState == T_WAIT) |-> bias)
    else $error("bias off during conversion");

  // Result written exactly when a conversion ends.
  result_store_a :
    assert property (@(posedge core_clk) disable iff (reset)
      (tState == T_WAIT && adcDone) |-> wrEn ##1 (tState != T_WAIT))
    else $error("result not stored on conversion end");

  // Full scan steps through every channel.
  scan_step_a :
    assert property (@(posedge core_clk) disable iff (reset || swRst)
      (tState == T_WAIT && adcDone && scanAll && chan != 3'h7) |=> chan == $past(chan) + 3'h1)
    else $error("scan channel did not advance");

  // A fault only rises on an enabled input.
  fault_mask_a :
    assert property (@(posedge core_clk) disable iff (reset)
      ((fault & ~$past(fault) & ~$past(checkEn)) == 4'h0))
    else $error("fault on disabled input");

  // Addressed sleep is refused with NAK.
  sleep_nak_a :
    assert property (@(posedge core_clk) disable iff (reset)
      (accept && cmd.op == sph_pkg::SPH_OP_SLEEP && !cmd.broadcast && pState == P_AWAKE
       && !(wdtEnable && wdtExpired) && !swRst)
      |=> resp.valid && resp.code == sph_pkg::SPH_RSP_NAK && pState == P_AWAKE)
    else $error("addressed sleep not refused");

  // Port 1 traffic cancels a pending sleep.
  sleep_cancel_a :
    assert property (@(posedge core_clk) disable iff (reset)
      (pState == P_SLEEP_WAIT && port1Activity && !accept && !wdtExpired && !swRst)
      |=> pState == P_AWAKE)
    else $error("sleep not cancelled");

  // No response to commands while the tone is sent.
  tone_ignore_a :
    assert property (@(posedge core_clk) disable iff (reset)
      (pState == P_WAKE_TX && $past(pState) == P_WAKE_TX) |-> !resp.valid)
    else $error("response while sending tone");

  // Broadcast reset does nothing.
  bcast_reset_a :
    assert property (@(posedge core_clk) disable iff (reset)
      (accept && cmd.op == sph_pkg::SPH_OP_RESET && cmd.broadcast) |=> !softReset && !resp.valid)
    else $error("broadcast reset acted");

  // Balance enable sets the run bit next cycle.
  bal_enable_a :
    assert property (@(posedge core_clk) disable iff (reset)
      (accept && cmd.op == sph_pkg::SPH_OP_BAL_ENABLE && !swRst
       && (pState == P_AWAKE || pState == P_SLEEP_WAIT || pState == P_ASLEEP))
      |=> balance_run_bit)
    else $error("balance run bit not set");

endmodule : sph_command_handler

//--- sph_adc_model.sv
module sph_adc_model (
  // Clock and reset.
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // Start request from the handler.
  input  wire logic                         adcStart,
  input  wire logic [sph_pkg::CHAN_W-1:0]   adcChan,
  // Conversion answer.
  output logic                              adcDone,
  output logic      [sph_pkg::RESULT_W-1:0] adcData
);
  logic [1:0] busyCnt;  // Cycles left until the answer.
  logic [2:0] chanHeld; // Channel captured at start.

  // Answers three cycles after a start; the result carries the channel so every slot differs.
  // Outside the done pulse the data is inverted each cycle, so stale values never pass.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      busyCnt  <= 2'h0;
      chanHeld <= 3'h0;
      adcDone  <= 1'b0;
      adcData  <= 14'h0000;
    end
    else if (adcStart)
    begin
      busyCnt  <= 2'h3;
      chanHeld <= adcChan;
      adcDone  <= 1'b0;
      adcData  <= ~adcData;
    end
    else
    begin
      busyCnt <= (busyCnt != 2'h0) ? busyCnt - 2'h1 : 2'h0;
      adcDone <= (busyCnt == 2'h1);
      adcData <= (busyCnt == 2'h1) ? {1'b0, chanHeld, 10'h100} : ~adcData;
    end
  end
endmodule : sph_adc_model

//--- stack_power_command_handler_test.sv
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
`define WAITFOR(cond, n) begin for (int k = 0; k < n; k++) begin @(posedge core_clk); #1; \
  if (cond) break; end if (!(cond)) begin err_count++; complete_run(); end end
module stack_power_command_handler_test;
  timeunit 1ns;
  timeprecision 100ps;
  // Stimulus registers, all driven at the rising edge.
  logic core_clk = 1'b0, reset = 1'b1, cmdValid = 1'b0, port1Activity = 1'b0, cfgLoad = 1'b0;
  logic wdtExpired = 1'b0, balanceStop = 1'b0, faultClear = 1'b0, toneIn = 1'b0, prevTone;
  logic isMaster = 1'b1, isTop = 1'b1, scanRequest = 1'b0, wdtEnable = 1'b0;
  sph_pkg::sph_rate_t rateSel = sph_pkg::SPH_RATE_500K;
  logic [3:0] cfgCheckEn = 4'h0;
  logic [13:0] extThreshold = 14'h0600;
  logic [63:0] regImage = 64'h0;
  logic [2:0] resultAddr = 3'h0;
  sph_pkg::sph_cmd_t cmd = '0;
  sph_pkg::sph_resp_t resp, got;
  logic adcStart, adcDone, toneOut, bias, sleepMode, runBit, softReset;
  logic [2:0] adcChan;
  logic [13:0] adcData, resultData;
  logic [3:0] tempFault, checkEn;
  logic [15:0] storedChecksum;
  logic [1:0] rstSeen = 2'h0;
  int err_count = 0, num_checks = 0, toneRise = 0;
  // Short counts keep the run brief; all expectations follow these values.
  sph_command_handler #(.DWELL_CYC(20), .SLEEP_500K(30), .TONE_HALF(5), .TOP_WAIT(40)) dut (
    .core_clk, .reset, .cmdValid, .cmd, .port1Activity, .isMaster, .isTop, .rateSel,
    .scanRequest, .wdtExpired, .wdtEnable, .balanceStop, .cfgLoad, .cfgCheckEn,
    .extThreshold, .faultClear, .regImage, .adcStart, .adcChan, .adcDone, .adcData, .resultAddr,
    .resultData, .toneIn, .toneOut, .thermistor_bias_output(bias), .tempFault,
    .ext_temp_check_enables(checkEn), .sleepMode, .balance_run_bit(runBit), .softReset,
    .storedChecksum, .resp);
  sph_adc_model adc (.core_clk, .reset, .adcStart, .adcChan, .adcDone, .adcData);
  always #2 core_clk = ~core_clk;
  // Counts rising edges of the wakeup tone and soft reset pulses.
  always @(posedge core_clk)
  begin
    prevTone <= toneOut;
    if (toneOut === 1'b1 && prevTone === 1'b0) toneRise++;
    if (softReset === 1'b1) rstSeen <= rstSeen + 2'h1;
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // Issues one command and keeps any response seen in the next three cycles.
  task automatic sendCmd(input sph_pkg::sph_op_t op, input logic bc);
    got = '0;
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmd <= '{op: op, broadcast: bc, chan: 3'h0};
    @(posedge core_clk);
    cmdValid <= 1'b0;
    repeat (3)
    begin
      #1;
      if (resp.valid === 1'b1) got = resp;
      @(posedge core_clk);
    end
    #1;
  endtask : sendCmd
  // Scan with one input checked: bias, dwell, stored results and threshold fault.
  task automatic scanCase();
    @(posedge core_clk);
    cfgCheckEn <= 4'h2;
    cfgLoad <= 1'b1;
    @(posedge core_clk);
    cfgLoad <= 1'b0;
    sendCmd(sph_pkg::SPH_OP_SCAN_TEMPS, 1'b1);
    `CHK("bias on", 1'b1, bias)
    repeat (16) @(posedge core_clk);
    #1 `CHK("dwell", 1'b0, adcStart)
    @(posedge core_clk);
    #1 `CHK("first start", 1'b1, adcStart)
    `WAITFOR(bias === 1'b0, 100)
    `CHK("fault", 4'h2, tempFault)
    @(posedge core_clk) resultAddr <= 3'h1;
    repeat (2) @(posedge core_clk);
    #1 `CHK("result 1", 14'h0500, resultData)
    @(posedge core_clk) resultAddr <= 3'h7;
    repeat (2) @(posedge core_clk);
    #1 `CHK("loopback", 14'h1D00, resultData)
    sendCmd(sph_pkg::SPH_OP_MEAS_TEMP, 1'b0);
    `CHK("measure bias", 1'b1, bias)
    `WAITFOR(bias === 1'b0, 40)
  endtask : scanCase
  // Addressed sleep refused, cancel by traffic, entry, then wakeup with tone and acknowledge.
  task automatic sleepCase();
    sendCmd(sph_pkg::SPH_OP_SLEEP, 1'b0);
    `CHK("addressed sleep", 3'h5, got)
    sendCmd(sph_pkg::SPH_OP_SLEEP, 1'b1);
    @(posedge core_clk) port1Activity <= 1'b1;
    @(posedge core_clk) port1Activity <= 1'b0;
    repeat (60) @(posedge core_clk);
    #1 `CHK("cancelled", 1'b0, sleepMode)
    sendCmd(sph_pkg::SPH_OP_SLEEP, 1'b1);
    `CHK("sleep ack", 3'h4, got)
    `WAITFOR(sleepMode === 1'b1, 30)
    toneRise = 0;
    sendCmd(sph_pkg::SPH_OP_WAKEUP, 1'b1);
    sendCmd(sph_pkg::SPH_OP_SLEEP, 1'b0);
    `CHK("tone ignore", 3'h0, got)
    `WAITFOR(resp.valid === 1'b1, 120)
    `CHK("wake ack", 3'h4, resp)
    `CHK("tone cycles", 4, toneRise)
    `CHK("awake", 1'b0, sleepMode)
  endtask : sleepCase
  // Watchdog expiry only counts when enabled; a neighbour's tone then wakes and relays.
  task automatic wdtCase();
    @(posedge core_clk) wdtExpired <= 1'b1;
    @(posedge core_clk) wdtEnable <= 1'b1;
    #1 `CHK("watchdog off", 1'b0, sleepMode)
    @(posedge core_clk) wdtExpired <= 1'b0;
    #1 `CHK("watchdog sleep", 1'b1, sleepMode)
    @(posedge core_clk) toneIn <= 1'b1;
    `WAITFOR(toneOut === 1'b1, 8)
    @(posedge core_clk) toneIn <= 1'b0;
    wdtEnable <= 1'b0;
    `WAITFOR(resp.valid === 1'b1, 120)
    `CHK("relay ack", 3'h4, resp)
  endtask : wdtCase
  // Checksum store and mismatch, then balance enable and both kinds of reset.
  task automatic regCase();
    @(posedge core_clk) regImage <= 64'h0001_0002_0004_0008;
    sendCmd(sph_pkg::SPH_OP_CALC_CSUM, 1'b0);
    `CHK("checksum", 16'h000F, storedChecksum)
    @(posedge core_clk) regImage <= 64'h0001_0002_0004_0009;
    sendCmd(sph_pkg::SPH_OP_CHECK_CSUM, 1'b0);
    `CHK("mismatch", 3'h6, got)
    sendCmd(sph_pkg::SPH_OP_BAL_ENABLE, 1'b1);
    `CHK("run bit", 1'b1, runBit)
    sendCmd(sph_pkg::SPH_OP_RESET, 1'b1);
    `CHK("bcast reset", 10'h048, {got, runBit, checkEn, rstSeen})
    sendCmd(sph_pkg::SPH_OP_RESET, 1'b0);
    repeat (2) @(posedge core_clk);
    #1 `CHK("soft reset", 23'h000001, {runBit, checkEn, storedChecksum, rstSeen})
    @(posedge core_clk) cfgLoad <= 1'b1;
    @(posedge core_clk) cfgLoad <= 1'b0;
    sendCmd(sph_pkg::SPH_OP_CALC_CSUM, 1'b0);
    sendCmd(sph_pkg::SPH_OP_CHECK_CSUM, 1'b0);
    `CHK("reload check", 7'h02, {got, checkEn})
  endtask : regCase
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1 `CHK("enables reset", 4'h0, checkEn)
    scanCase();
    sleepCase();
    wdtCase();
    regCase();
    complete_run();
  end
endmodule : stack_power_command_handler_test
